/* File: hdl/lgc_pkg.sv */
// Shared constants for the global-control host port, both ends.
// Assumes one 250 MHz clock and a synchronous active-high reset.
package lgc_pkg;
  localparam int unsigned NUM_PORTS   = 4;
  localparam int unsigned ADDR_W      = 6;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned PORT_SHIFT  = 4;
  // -------------------------------------------------------------
  // Per-port register offsets (low nibble of the address)
  // -------------------------------------------------------------
  localparam logic [3:0] OFS_GCR  = 4'h0;
  localparam logic [3:0] OFS_TCR  = 4'h1;
  localparam logic [3:0] OFS_RCR  = 4'h2;
  localparam logic [3:0] OFS_SR   = 4'h3;
  localparam logic [3:0] OFS_SRL  = 4'h4;
  localparam logic [3:0] OFS_SRIE = 4'h5;
  // -------------------------------------------------------------
  // Field positions
  // -------------------------------------------------------------
  localparam int unsigned GCR_RATE  = 7;
  localparam int unsigned GCR_SONET = 6;
  localparam int unsigned GCR_LOCAL = 5;
  localparam int unsigned GCR_REMOTE = 4;
  localparam int unsigned GCR_SRST  = 0;
  localparam int unsigned TCR_BIN   = 6;
  localparam int unsigned TCR_TINV  = 5;
  localparam int unsigned RCR_BIN   = 6;
  localparam int unsigned RCR_RINV  = 5;
  localparam logic [7:0] GCR_MASK   = 8'hFD;
  localparam logic [7:0] TCR_MASK   = 8'h7E;
  localparam logic [7:0] RCR_MASK   = 8'hFF;
  localparam logic [7:0] STAT_MASK  = 8'h3F;
  localparam logic [7:0] REG_RST    = 8'h00;
  // Host-side strobe width, given in ns and rounded up to clocks
  localparam int unsigned STROBE_NS = 20;
  localparam int unsigned CLK_NS    = 4;
  localparam int unsigned STROBE_CY = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [1:0] {
    LGC_LOOP_NONE    = 2'b00,
    LGC_LOOP_REMOTE  = 2'b01,
    LGC_LOOP_ANALOG  = 2'b10,
    LGC_LOOP_DIGITAL = 2'b11
  } lgc_loop_t;
endpackage

/* File: hdl/lgc_bus_if.sv */
// Pin-level bus between host processor and the line interface device.
// Two-way data bus and open-drain interrupt resolved here from enables.
`timescale 1ns/1ps
interface lgc_bus_if;
  logic       rst_n;
  logic       float_n;
  logic       strobe_style_select;
  logic       ale;
  logic       cs_n;
  logic       wr_rw;
  logic       rd_ds_n;
  logic [5:0] addr;
  logic [7:0] d_host;
  logic       d_host_oe;
  logic [7:0] d_dev;
  logic       d_dev_oe;
  logic       int_low;
  wire  [7:0] data  = d_dev_oe ? d_dev : (d_host_oe ? d_host : 8'hFF);
  wire        int_n = int_low ? 1'b0 : 1'b1;
  modport dev  (input rst_n, float_n, strobe_style_select, ale, cs_n,
                wr_rw, rd_ds_n, addr, d_host, d_host_oe,
                output d_dev, d_dev_oe, int_low);
  modport host (output rst_n, float_n, strobe_style_select, ale, cs_n,
                wr_rw, rd_ds_n, addr, d_host, d_host_oe,
                input d_dev, d_dev_oe, int_low, data);
endinterface

/* File: hdl/lgc_device.sv */
// Device end: global control pins and the asynchronous host port.
// Bus pins are sampled through two flops; writes act on strobe edges, reads on strobe level.
`timescale 1ns/1ps
// How it works
// - Low global reset clears all, holds reset
// - Host holds reset low two master clocks
// - Float low with test reset low tristates outputs
// - Config select: 0 bus, 1 pin straps
// - Master clock tied high uses transmit clock
// - Loop bits: none, remote, analog, digital
// - Rate bit: 0 DS3, 1 E3/STS-1
// - Second bit: E3/STS-1, or AIS pattern
// - Rx select: bipolar pulses or binary plus violation
// - Tx select: bipolar inputs or binary, encode
// - Rx invert: falling edge 0, rising 1
// - Tx invert: sample rising 0, falling 1
// - Style: 0 separate strobes, 1 data strobe
// - Address latch transparent on ALE high
// - Mux bus ties address to data; else ALE high
// - Strobes ignored without chip select
// - Write strobe stores data bus
// - Read strobe drives register onto bus
// - Direction: 1 read, 0 write
// - Data strobe rising edge commits write
// - Six address bits pick the register
// - Interrupt low while unmasked source active
// - Port soft reset restores its registers
module lgc_device
  import lgc_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  sys_rst_i,
  // Host bus pins
  lgc_bus_if.dev                     bus,
  // Global straps
  input  wire logic                  hardwired_config_select_i,
  input  wire logic                  test_port_reset_n_i,
  input  wire logic                  ds3_master_clock_i,
  input  wire logic                  e3_master_clock_i,
  input  wire logic                  sonet_master_clock_i,
  // Per-port pin straps (hardwired mode)
  input  wire logic [NUM_PORTS-1:0]  pin_rate_mode_bit_i,
  input  wire logic [NUM_PORTS-1:0]  pin_sonet_or_ais_select_i,
  input  wire logic [NUM_PORTS-1:0]  pin_local_loop_select_i,
  input  wire logic [NUM_PORTS-1:0]  pin_remote_loop_select_i,
  input  wire logic [NUM_PORTS-1:0]  pin_rx_binary_interface_i,
  input  wire logic [NUM_PORTS-1:0]  pin_tx_binary_interface_i,
  input  wire logic [NUM_PORTS-1:0]  pin_rx_clock_invert_i,
  input  wire logic [NUM_PORTS-1:0]  pin_tx_clock_invert_i,
  // Per-port status from line datapaths
  input  wire logic [NUM_PORTS-1:0]  pattern_detector_status_i,
  input  wire logic [NUM_PORTS-1:0]  port_event_i,
  // Effective per-port configuration
  output logic [NUM_PORTS-1:0]       rate_mode_bit_o,
  output logic [NUM_PORTS-1:0]       sonet_or_ais_select_o,
  output lgc_loop_t [NUM_PORTS-1:0]  loop_mode_o,
  output logic [NUM_PORTS-1:0]       rx_binary_interface_o,
  output logic [NUM_PORTS-1:0]       tx_binary_interface_o,
  output logic [NUM_PORTS-1:0]       rx_update_rising_o,
  output logic [NUM_PORTS-1:0]       tx_sample_falling_o,
  output logic [NUM_PORTS-1:0]       recover_from_tx_clock_o,
  // Global status
  output logic                       in_reset_o,
  output logic                       outputs_float_o
);
  import lgc_pkg::*;

  // -------------------------------------------------------------
  // Input synchronisers
  // -------------------------------------------------------------
  localparam int unsigned SW = 12 + ADDR_W + DATA_W;
  logic [SW-1:0] s1_q;
  logic [SW-1:0] s2_q;
  wire  [SW-1:0] raw = {bus.rst_n, bus.float_n, bus.strobe_style_select,
                        bus.ale, bus.cs_n, bus.wr_rw, bus.rd_ds_n,
                        ds3_master_clock_i, e3_master_clock_i,
                        sonet_master_clock_i, hardwired_config_select_i,
                        test_port_reset_n_i, bus.addr, bus.d_host};
  always_ff @(posedge clk_i) begin
    s1_q <= raw;
    s2_q <= s1_q;
  end
  wire       rst_n_s   = s2_q[SW-1];
  wire       float_n_s = s2_q[SW-2];
  wire       style_s   = s2_q[SW-3];
  wire       ale_s     = s2_q[SW-4];
  wire       cs_n_s    = s2_q[SW-5];
  wire       wr_rw_s   = s2_q[SW-6];
  wire       rd_ds_n_s = s2_q[SW-7];
  wire       t3_s      = s2_q[SW-8];
  wire       e3_s      = s2_q[SW-9];
  wire       st_s      = s2_q[SW-10];
  wire       hw_s      = s2_q[SW-11];
  wire       tprst_n_s = s2_q[SW-12];
  wire [5:0] addr_s    = s2_q[DATA_W +: ADDR_W];
  wire [7:0] data_s    = s2_q[DATA_W-1:0];

  // Reset pin acts on any clock with pin low, no host strobe needed
  wire rst_all = sys_rst_i | ~rst_n_s;
  assign in_reset_o = rst_all;

  // -------------------------------------------------------------
  // Address latch and strobe decode
  // -------------------------------------------------------------
  logic [5:0] alat_q;
  logic       ds_prev_q;
  logic       wr_prev_q;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      alat_q    <= '0;
      ds_prev_q <= 1'b1;
      wr_prev_q <= 1'b1;
    end else begin
      if (ale_s)
        alat_q <= addr_s;
      ds_prev_q <= rd_ds_n_s;
      wr_prev_q <= wr_rw_s;
    end
  end
  wire [5:0] addr_eff = ale_s ? addr_s : alat_q;
  wire       sel      = ~cs_n_s & ~hw_s;
  // Separate strobes: write commits on write-strobe release
  wire wr_sep = ~style_s & wr_prev_q & ~wr_rw_s ? 1'b0 :
                (~style_s & ~wr_prev_q & wr_rw_s);
  // Data strobe: commit on rising edge with direction low
  wire wr_ds  = style_s & ~ds_prev_q & rd_ds_n_s & ~wr_rw_s;
  wire wr_go  = sel & (wr_sep | wr_ds);
  wire rd_act = ~cs_n_s & (style_s ? (~rd_ds_n_s & wr_rw_s)
                                   : ~rd_ds_n_s);

  // -------------------------------------------------------------
  // Register file, one group per port
  // -------------------------------------------------------------
  wire [1:0] port_sel = addr_eff[ADDR_W-1:PORT_SHIFT];
  wire [3:0] ofs      = addr_eff[PORT_SHIFT-1:0];
  logic [7:0] gcr_q  [NUM_PORTS];
  logic [7:0] tcr_q  [NUM_PORTS];
  logic [7:0] rcr_q  [NUM_PORTS];
  logic [7:0] srl_q  [NUM_PORTS];
  logic [7:0] srie_q [NUM_PORTS];
  logic [7:0] sr_w   [NUM_PORTS];
  logic [NUM_PORTS-1:0] irq_w;

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    wire hit   = wr_go & (port_sel == 2'(p));
    wire srst  = gcr_q[p][GCR_SRST];
    assign sr_w[p] = {2'b00, 1'b0, pattern_detector_status_i[p],
                      3'b000, port_event_i[p]} & STAT_MASK;
    wire [7:0] ev  = {3'b000, pattern_detector_status_i[p], 3'b000,
                      port_event_i[p]};
    always_ff @(posedge clk_i) begin
      if (rst_all || srst) begin
        gcr_q[p]  <= REG_RST;
        tcr_q[p]  <= REG_RST;
        rcr_q[p]  <= REG_RST;
        srl_q[p]  <= REG_RST;
        srie_q[p] <= REG_RST;
      end else begin
        if (hit && ofs == OFS_GCR)  gcr_q[p]  <= data_s & GCR_MASK;
        if (hit && ofs == OFS_TCR)  tcr_q[p]  <= data_s & TCR_MASK;
        if (hit && ofs == OFS_RCR)  rcr_q[p]  <= data_s & RCR_MASK;
        if (hit && ofs == OFS_SRIE) srie_q[p] <= data_s & STAT_MASK;
        // Set beats write-one-to-clear in the same cycle
        srl_q[p] <= ((hit && ofs == OFS_SRL) ? (srl_q[p] & ~data_s)
                                             : srl_q[p]) | ev;
      end
    end
    assign irq_w[p] = |(srl_q[p] & srie_q[p]);
    // Config source: registers or pin straps
    assign rate_mode_bit_o[p]       = hw_s ? pin_rate_mode_bit_i[p]
                                           : gcr_q[p][GCR_RATE];
    assign sonet_or_ais_select_o[p] = hw_s ? pin_sonet_or_ais_select_i[p]
                                           : gcr_q[p][GCR_SONET];
    assign loop_mode_o[p] = lgc_loop_t'(hw_s ?
        {pin_local_loop_select_i[p], pin_remote_loop_select_i[p]} :
        {gcr_q[p][GCR_LOCAL], gcr_q[p][GCR_REMOTE]});
    assign rx_binary_interface_o[p] = hw_s ? pin_rx_binary_interface_i[p]
                                           : rcr_q[p][RCR_BIN];
    assign tx_binary_interface_o[p] = hw_s ? pin_tx_binary_interface_i[p]
                                           : tcr_q[p][TCR_BIN];
    assign rx_update_rising_o[p]    = hw_s ? pin_rx_clock_invert_i[p]
                                           : rcr_q[p][RCR_RINV];
    assign tx_sample_falling_o[p]   = hw_s ? pin_tx_clock_invert_i[p]
                                           : tcr_q[p][TCR_TINV];
    // Tied-high master clock reads as steady high after sync
    assign recover_from_tx_clock_o[p] =
        ~rate_mode_bit_o[p] ? t3_s :
        (sonet_or_ais_select_o[p] ? st_s : e3_s);
  end

  // -------------------------------------------------------------
  // Read path and pin drivers
  // -------------------------------------------------------------
  wire [7:0] rd_mux =
      (ofs == OFS_GCR)  ? gcr_q[port_sel]  :
      (ofs == OFS_TCR)  ? tcr_q[port_sel]  :
      (ofs == OFS_RCR)  ? rcr_q[port_sel]  :
      (ofs == OFS_SR)   ? sr_w[port_sel]   :
      (ofs == OFS_SRL)  ? srl_q[port_sel]  :
      (ofs == OFS_SRIE) ? srie_q[port_sel] : 8'h00;
  wire floating = ~float_n_s & ~tprst_n_s;
  logic [7:0] dout_q;
  always_ff @(posedge clk_i) begin
    if (rst_all)
      dout_q <= 8'h00;
    else
      dout_q <= rd_mux;
  end
  assign outputs_float_o = floating;
  assign bus.d_dev    = dout_q;
  assign bus.d_dev_oe = rd_act & ~hw_s & ~floating & ~rst_all;
  assign bus.int_low  = |irq_w & ~floating;
endmodule

/* File: hdl/lgc_host.sv */
// Host end: drives the asynchronous bus for single register accesses.
// Assumes the device samples pins through two flops at the same clock.
`timescale 1ns/1ps
module lgc_host
  import lgc_pkg::*;
(
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         sys_rst_i,
  // Device pins
  lgc_bus_if.host           bus,
  // User request
  input  wire logic         req_valid_i,
  input  wire logic         req_write_i,
  input  wire logic [5:0]   req_addr_i,
  input  wire logic [7:0]   req_wdata_i,
  input  wire logic         strobe_style_i,
  input  wire logic         mux_bus_i,
  input  wire logic         dev_reset_i,
  input  wire logic         float_req_i,
  output logic              req_ready_o,
  output logic              rsp_valid_o,
  output logic [7:0]        rsp_rdata_o,
  output logic              irq_o
);
  import lgc_pkg::*;
  typedef enum logic [1:0] {
    LGC_IDLE = 2'b00, LGC_ADDR = 2'b01, LGC_STRB = 2'b10, LGC_HOLD = 2'b11
  } lgc_hstate_t;
  // Extra wait covers the device's two-flop sampling delay
  localparam logic [3:0] STRB_CY = 4'(STROBE_CY + 3);
  lgc_hstate_t st_q;
  logic [3:0]  cnt_q;
  logic        wr_q;
  logic [5:0]  addr_q;
  logic [7:0]  wd_q;
  logic [7:0]  rd_q;
  logic        rsp_q;
  logic [1:0]  i1_q;
  wire done = (cnt_q == 4'd0);
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_q <= LGC_IDLE; cnt_q <= '0; wr_q <= 1'b0;
      addr_q <= '0; wd_q <= '0; rd_q <= '0; rsp_q <= 1'b0; i1_q <= '0;
    end else begin
      rsp_q <= 1'b0;
      i1_q  <= {i1_q[0], bus.int_low};
      unique case (st_q)
        LGC_IDLE: if (req_valid_i) begin
          st_q <= LGC_ADDR; wr_q <= req_write_i; cnt_q <= STRB_CY;
          addr_q <= req_addr_i; wd_q <= req_wdata_i;
        end
        LGC_ADDR: if (done) begin st_q <= LGC_STRB; cnt_q <= STRB_CY; end
                  else cnt_q <= cnt_q - 4'd1;
        LGC_STRB: if (done) begin
          st_q <= LGC_HOLD; cnt_q <= STRB_CY;
          if (!wr_q) begin rd_q <= bus.data; rsp_q <= 1'b1; end
        end else cnt_q <= cnt_q - 4'd1;
        LGC_HOLD: if (done) st_q <= LGC_IDLE;
                  else cnt_q <= cnt_q - 4'd1;
      endcase
    end
  end
  wire strobing = (st_q == LGC_STRB);
  wire active   = (st_q != LGC_IDLE);
  assign bus.rst_n   = ~dev_reset_i;
  assign bus.float_n = ~float_req_i;
  assign bus.strobe_style_select = strobe_style_i;
  // Non-muxed: ALE high; muxed: ALE high while address on D, dropped as D turns to write data
  assign bus.ale  = ~mux_bus_i | (st_q == LGC_ADDR);
  // Muxed board wiring: address pins follow the low data lines
  assign bus.addr = mux_bus_i ? bus.d_host[5:0] : addr_q;
  assign bus.cs_n = ~active;
  assign bus.wr_rw   = strobe_style_i ? ~wr_q
                                        : ~(strobing & wr_q);
  assign bus.rd_ds_n = strobe_style_i ? ~strobing
                                        : ~(strobing & ~wr_q);
  assign bus.d_host    = (mux_bus_i && st_q == LGC_ADDR) ? {2'b00, addr_q}
                                                         : wd_q;
  assign bus.d_host_oe = active & (wr_q | (mux_bus_i & st_q == LGC_ADDR));
  assign req_ready_o = (st_q == LGC_IDLE);
  assign rsp_valid_o = rsp_q;
  assign rsp_rdata_o = rd_q;
  assign irq_o       = i1_q[1];
endmodule

/* File: verification/lgc_chk.sv */
// Checker for the host bus between the two ends of the host port.
// Assumes one clock, sync reset, pins sampled by the device 2 flops late.
`timescale 1ns/1ps
module lgc_chk (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  // Bus signals
  input  wire logic rst_n,
  input  wire logic strobe_style_select,
  input  wire logic cs_n,
  input  wire logic wr_rw,
  input  wire logic rd_ds_n,
  input  wire logic d_host_oe,
  input  wire logic d_dev_oe,
  input  wire logic int_low
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // --------------------------------------------------------------
  // Device side
  // --------------------------------------------------------------
  // Device view lags the pins, so allow up to three cycles of lag
  a_oe_needs_cs: assert property (d_dev_oe |-> (!cs_n || !$past(cs_n)
    || !$past(cs_n, 2) || !$past(cs_n, 3)))
    else $error("data driven without chip select");
  a_oe_no_clash: assert property (d_dev_oe |-> !d_host_oe)
    else $error("both ends drive the data bus");
  a_oe_sep_read: assert property (d_dev_oe && !strobe_style_select
    |-> (!rd_ds_n || !$past(rd_ds_n) || !$past(rd_ds_n, 2)
    || !$past(rd_ds_n, 3)))
    else $error("data driven without read strobe");
  a_oe_ds_read: assert property (d_dev_oe && strobe_style_select
    |-> (wr_rw || $past(wr_rw) || $past(wr_rw, 2) || $past(wr_rw, 3)))
    else $error("data driven on a data strobe write");
  a_rst_no_int: assert property (!rst_n [*4] |=> !int_low)
    else $error("interrupt active during global reset");
  // --------------------------------------------------------------
  // Host side
  // --------------------------------------------------------------
  a_strobe_cs: assert property ($fell(rd_ds_n) |-> !cs_n)
    else $error("strobe without chip select");
  a_cs_setup: assert property ($fell(cs_n)
    |-> (rd_ds_n && (wr_rw || strobe_style_select)) [*4])
    else $error("strobe too soon after chip select");
  a_strobe_width: assert property ($fell(rd_ds_n) |-> !rd_ds_n [*5])
    else $error("strobe too short");
  a_wr_has_data: assert property (!strobe_style_select && !wr_rw && !cs_n
    |-> d_host_oe)
    else $error("write strobe without host data");
  a_ds_dir_hold: assert property (strobe_style_select && !rd_ds_n
    && $past(!rd_ds_n) |-> $stable(wr_rw))
    else $error("direction changed under data strobe");
endmodule

/* File: verification/liu_global_control_host_port_bench.sv */
// Testbench: host end and device end joined by the bus interface.
// Assumes the user side of the host end as the only access path.
`timescale 1ns/1ps
module liu_global_control_host_port_bench;
  import lgc_pkg::*;
  logic                       clk_i     = 1'b0;
  logic                       sys_rst_i = 1'b1;
  logic                       hw_sel    = 1'b0;
  logic                       tst_rst_n = 1'b1;
  logic [2:0]                 mclk      = 3'b000;
  logic [3:0]                 straps    = 4'h0;
  logic [3:0]                 pat_st    = 4'h0;
  logic [3:0]                 evt       = 4'h0;
  logic                       req_valid = 1'b0;
  logic                       req_write = 1'b0;
  logic [5:0]                 req_addr  = 6'h00;
  logic [7:0]                 req_wdata = 8'h00;
  logic                       sty       = 1'b0;
  logic                       mux       = 1'b0;
  logic                       dev_rst   = 1'b0;
  logic                       flt       = 1'b0;
  logic [7:0]                 q;
  logic [7:0]                 v;
  logic [1:0]                 p;
  logic [3:0]                 rate_o, sonet_o, rxb_o, txb_o, rxr_o, txf_o;
  logic [3:0]                 rec_o;
  lgc_loop_t [NUM_PORTS-1:0]  loop_o;
  logic                       in_rst_o, float_o, req_ready_o, rsp_valid_o;
  logic [7:0]                 rsp_rdata_o;
  logic                       irq_o;
  int                         fail_count = 0;
  int                         num_checks = 0;
  always #2 clk_i = ~clk_i;
  lgc_bus_if u_lgc_bus_if ();
  lgc_device u_lgc_device (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus(u_lgc_bus_if),
    .hardwired_config_select_i(hw_sel), .test_port_reset_n_i(tst_rst_n),
    .ds3_master_clock_i(mclk[0]), .e3_master_clock_i(mclk[1]),
    .sonet_master_clock_i(mclk[2]), .pin_rate_mode_bit_i(straps),
    .pin_sonet_or_ais_select_i(~straps), .pin_local_loop_select_i(straps),
    .pin_remote_loop_select_i(~straps), .pin_rx_binary_interface_i(straps),
    .pin_tx_binary_interface_i(straps), .pin_rx_clock_invert_i(straps),
    .pin_tx_clock_invert_i(straps), .pattern_detector_status_i(pat_st),
    .port_event_i(evt), .rate_mode_bit_o(rate_o),
    .sonet_or_ais_select_o(sonet_o), .loop_mode_o(loop_o),
    .rx_binary_interface_o(rxb_o), .tx_binary_interface_o(txb_o),
    .rx_update_rising_o(rxr_o), .tx_sample_falling_o(txf_o),
    .recover_from_tx_clock_o(rec_o), .in_reset_o(in_rst_o),
    .outputs_float_o(float_o));
  lgc_host u_lgc_host (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus(u_lgc_bus_if),
    .req_valid_i(req_valid), .req_write_i(req_write),
    .req_addr_i(req_addr), .req_wdata_i(req_wdata),
    .strobe_style_i(sty), .mux_bus_i(mux), .dev_reset_i(dev_rst),
    .float_req_i(flt), .req_ready_o(req_ready_o),
    .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o), .irq_o(irq_o));
  lgc_chk u_lgc_chk (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .rst_n(u_lgc_bus_if.rst_n),
    .strobe_style_select(u_lgc_bus_if.strobe_style_select),
    .cs_n(u_lgc_bus_if.cs_n), .wr_rw(u_lgc_bus_if.wr_rw),
    .rd_ds_n(u_lgc_bus_if.rd_ds_n), .d_host_oe(u_lgc_bus_if.d_host_oe),
    .d_dev_oe(u_lgc_bus_if.d_dev_oe), .int_low(u_lgc_bus_if.int_low));
  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  task automatic complete_run();
    if (fail_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen,
                     input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // One access; read data lands in q, left unknown if never answered
  task automatic acc(input logic w, input logic [5:0] a,
                     input logic [7:0] d);
    int n;
    q = 8'hxx;
    @(posedge clk_i);
    #1;
    req_valid = 1'b1; req_write = w; req_addr = a; req_wdata = d;
    n = 0;
    do begin @(posedge clk_i); n++; end
    while (req_ready_o !== 1'b1 && n < 100);
    #1 req_valid = 1'b0;
    n = 0;
    do begin
      @(posedge clk_i);
      #1 n++;
      if (rsp_valid_o === 1'b1) q = rsp_rdata_o;
    end while (req_ready_o !== 1'b1 && n < 100);
  endtask
  // --------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------
  initial begin
    #160000 fail_count++;
    complete_run();
  end
  initial begin
    tick(5);
    sys_rst_i = 1'b0;
    tick(3);
    acc(1'b0, {2'd0, OFS_GCR}, 8'h00);
    chk("gcr0_reset", q, REG_RST);
    // All four style and bus form pairs, covering each loop code and both rates
    for (int s = 0; s < 4; s++) begin
      sty = s[0];
      mux = s[1];
      p = s[1:0];
      v = {s[0], s[1], s[1:0], 4'h0};
      acc(1'b1, {p, OFS_GCR}, v);
      acc(1'b0, {p, OFS_GCR}, 8'h00);
      chk("gcr_read", q, v & GCR_MASK);
      chk("loop", {6'd0, loop_o[p]}, {6'd0, v[5:4]});
      chk("rate", {7'd0, rate_o[p]}, {7'd0, v[7]});
      chk("sonet", {7'd0, sonet_o[p]}, {7'd0, v[6]});
    end
    for (int i = 0; i < 2; i++) begin
      v = (i == 0) ? 8'hFF : 8'h00;
      acc(1'b1, {2'd2, OFS_TCR}, v);
      acc(1'b1, {2'd2, OFS_RCR}, v);
      acc(1'b0, {2'd2, OFS_TCR}, 8'h00);
      chk("tcr_read", q, v & TCR_MASK);
      chk("txrx_cfg", {4'd0, txb_o[2], txf_o[2], rxb_o[2], rxr_o[2]},
          {4'd0, {4{v[6]}}});
    end
    acc(1'b1, 6'h0F, 8'hAA);
    acc(1'b0, 6'h0F, 8'h00);
    chk("unmapped", q, 8'h00);
    acc(1'b1, {2'd1, OFS_GCR}, 8'h91);
    acc(1'b0, {2'd1, OFS_GCR}, 8'h00);
    chk("soft_reset", q, REG_RST);
    // Interrupt raised, masked, then serviced
    pat_st[0] = 1'b1;
    evt[0] = 1'b1;
    acc(1'b1, {2'd0, OFS_SRIE}, 8'h01);
    tick(6);
    chk("irq_set", {7'd0, irq_o}, 8'h01);
    acc(1'b0, {2'd0, OFS_SR}, 8'h00);
    chk("status", q, 8'h11 & STAT_MASK);
    acc(1'b1, {2'd0, OFS_SRIE}, 8'h00);
    tick(6);
    chk("irq_masked", {7'd0, irq_o}, 8'h00);
    evt[0] = 1'b0;
    acc(1'b1, {2'd0, OFS_SRL}, 8'h01);
    acc(1'b1, {2'd0, OFS_SRIE}, 8'h01);
    tick(6);
    chk("irq_serviced", {7'd0, irq_o}, 8'h00);
    // Ports 0..2 are DS3, port 3 is STS-1
    for (int i = 0; i < 3; i++) begin
      mclk = 3'b001 << i;
      tick(6);
      chk("recover", {4'd0, rec_o},
          (i == 0) ? 8'h07 : ((i == 1) ? 8'h00 : 8'h08));
    end
    mclk = 3'b000;
    hw_sel = 1'b1;
    straps = 4'b0101;
    tick(6);
    chk("hw_rate", {4'd0, rate_o}, 8'h05);
    chk("hw_loop", {6'd0, loop_o[0]}, {6'd0, LGC_LOOP_ANALOG});
    acc(1'b1, {2'd0, OFS_GCR}, 8'hFF);
    hw_sel = 1'b0;
    tick(6);
    chk("hw_ignored", {4'd0, rate_o}, 8'h08);
    tst_rst_n = 1'b0;
    flt = 1'b1;
    tick(6);
    chk("float_set", {7'd0, float_o}, 8'h01);
    // Floated device leaves the bus to its pull-up level
    acc(1'b0, {2'd0, OFS_GCR}, 8'h00);
    chk("float_bus", q, 8'hFF);
    tst_rst_n = 1'b1;
    tick(6);
    chk("float_gated", {7'd0, float_o}, 8'h00);
    flt = 1'b0;
    // Pin reset held well past two master clocks
    dev_rst = 1'b1;
    tick(6);
    chk("in_reset", {7'd0, in_rst_o}, 8'h01);
    chk("rate_cleared", {4'd0, rate_o}, 8'h00);
    dev_rst = 1'b0;
    tick(6);
    chk("out_of_reset", {7'd0, in_rst_o}, 8'h00);
    acc(1'b0, {2'd3, OFS_GCR}, 8'h00);
    chk("gcr3_cleared", q, REG_RST);
    complete_run();
  end
endmodule
